/* File: digital_port_counter_unit.sv */
// Digital port and counter unit with AXI4-Lite register access
// Operation
// - Three independent counters, each with a 32-bit count.
// - Each counter's A, B and reset inputs selectable from any port line.
// - Plain mode counts one per pulse on input A, up to 12.5 MHz.
// - At top of range the count wraps to the range minimum.
// - A routed reset line clears the counter at any time.
// - Quadrature mode decodes A and phase-shifted B, counting up or down.
// - A counter stays idle until its needed lines are assigned.
// - Up/down and quadrature counts are signed 32-bit; plain count is unsigned.
// - Pulse-time mode measures the interval between rising edges on A, long range.
// - Two 16-line ports; every line works as input or output.
// - Direction is chosen per group of eight adjacent lines.
// - After reset port A is input and port B is output.
// - Digital inputs are sampled on the analog sample instants.
// - Sample clock frequency can be trimmed from a time reference.
`timescale 1ns/1ns
`include "dpc_cfg.svh"
module digital_port_counter_unit import dpc_pkg::*; #(
	parameter int          NUM_CNT          = 3,
	parameter logic [31:0] PTIME_MAX_CYCLES =
		32'(`DPC_PTIME_MAX_MS * `DPC_PS_PER_MS / `DPC_CLK_PERIOD_PS)
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic [31:0] line_in_i,
	output logic      [31:0] line_out_o,
	output logic      [31:0] line_oe_o,
	output logic             sample_tick_o
);
	// Lines 0..15 form port A, 16..31 port B; one direction bit per byte
	word_t       line_sync_q;
	logic [3:0]  dir, next_dir;
	word_t       out_data, next_out_data;
	word_t       nco_inc, next_nco_inc;
	word_t       nco_phase, next_nco_phase;
	logic        next_tick;
	word_t       in_sample, next_in_sample;
	word_t       cnt_cfg [NUM_CNT];
	word_t       next_cnt_cfg [NUM_CNT];
	logic [NUM_CNT-1:0] clr_pulse, next_clr_pulse;
	word_t       cnt_count [NUM_CNT];
	word_t       cnt_period [NUM_CNT];

	logic        aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0]  aw_addr, next_aw_addr;
	word_t       w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	word_t       next_rdata;
	logic        do_write, wr_hit;
	logic [31:0] next_line_oe;

	line_sync #(
		.W(32)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i  (rst_b_i),
		.async_i  (line_in_i),
		.sync_o   (line_sync_q)
	);

	function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] strb);
		word_t r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		logic [3:0] idx;
		idx = a[7:4] - `DPC_OFS_CNT_BASE;
		if (a <= `DPC_OFS_NCO_INC) return 1'b1;
		return (a[7:4] >= `DPC_OFS_CNT_BASE) && (32'(idx) < NUM_CNT) && (a[3:2] <= `DPC_SUB_PERIOD);
	endfunction

	function automatic word_t read_reg(input logic [7:0] a);
		logic [3:0] idx;
		word_t r;
		idx = a[7:4] - `DPC_OFS_CNT_BASE;
		r = '0;
		case (a)
			`DPC_OFS_DIR:       r = {28'h0, dir};
			`DPC_OFS_OUT:       r = out_data;
			`DPC_OFS_IN_SAMPLE: r = in_sample;
			`DPC_OFS_IN_LIVE:   r = line_sync_q;
			`DPC_OFS_NCO_INC:   r = nco_inc;
			default: begin
				for (int n = 0; n < NUM_CNT; n++) begin
					if (32'(idx) == n && a[7:4] >= `DPC_OFS_CNT_BASE) begin
						case (a[3:2])
							`DPC_SUB_CFG:    r = cnt_cfg[n] & ~(32'h1 << `DPC_CFG_CLR_BIT);
							`DPC_SUB_COUNT:  r = cnt_count[n];
							`DPC_SUB_PERIOD: r = cnt_period[n];
							default:         r = '0;
						endcase
					end
				end
			end
		endcase
		return r;
	endfunction

	// Bus slave: address and data are taken in either order, response after both
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid_o;
		next_bresp   = s_axi_bresp_o;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_held = 1'b1;
			next_aw_addr = {s_axi_awaddr_i[7:2], 2'b00};
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata_i;
			next_w_strb = s_axi_wstrb_i;
		end
		if (s_axi_bvalid_o && s_axi_bready_i) next_bvalid = 1'b0;
		do_write = aw_held && w_held && !s_axi_bvalid_o;
		wr_hit   = addr_known(aw_addr);
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? `DPC_RESP_OKAY : `DPC_RESP_DECERR;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	always_comb begin
		next_rvalid = s_axi_rvalid_o;
		next_rdata  = s_axi_rdata_o;
		next_rresp  = s_axi_rresp_o;
		if (s_axi_rvalid_o && s_axi_rready_i) next_rvalid = 1'b0;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_rvalid = 1'b1;
			next_rdata  = read_reg({s_axi_araddr_i[7:2], 2'b00});
			next_rresp  = addr_known({s_axi_araddr_i[7:2], 2'b00}) ? `DPC_RESP_OKAY : `DPC_RESP_DECERR;
		end
		next_arready = !next_rvalid;
	end

	// Register file
	always_comb begin
		logic [3:0] widx;
		widx = aw_addr[7:4] - `DPC_OFS_CNT_BASE;
		next_dir       = dir;
		next_out_data  = out_data;
		next_nco_inc   = nco_inc;
		next_clr_pulse = '0;
		for (int n = 0; n < NUM_CNT; n++) next_cnt_cfg[n] = cnt_cfg[n];
		if (do_write && wr_hit) begin
			case (aw_addr)
				`DPC_OFS_DIR:     next_dir = w_strb[0] ? w_data[3:0] : dir;
				`DPC_OFS_OUT:     next_out_data = merge(out_data, w_data, w_strb);
				`DPC_OFS_NCO_INC: next_nco_inc = merge(nco_inc, w_data, w_strb);
				default: begin
					for (int n = 0; n < NUM_CNT; n++) begin
						if (32'(widx) == n && aw_addr[3:2] == `DPC_SUB_CFG) begin
							next_cnt_cfg[n] = merge(cnt_cfg[n], w_data, w_strb) & ~(32'h1 << `DPC_CFG_CLR_BIT);
							// Clear bit acts once and is not stored
							next_clr_pulse[n] = w_strb[3] & w_data[`DPC_CFG_CLR_BIT];
						end
					end
				end
			endcase
		end
	end

	// Sample clock generator and aligned input sampling
	always_comb begin
		{next_tick, next_nco_phase} = {1'b0, nco_phase} + {1'b0, nco_inc};
		next_in_sample = sample_tick_o ? line_sync_q : in_sample;
		for (int g = 0; g < 4; g++) next_line_oe[8*g +: 8] = {8{dir[g]}};
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_held         <= 1'b0;
			aw_addr         <= '0;
			w_held          <= 1'b0;
			w_data          <= '0;
			w_strb          <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `DPC_RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= `DPC_RESP_OKAY;
			dir             <= `DPC_DIR_RST;
			out_data        <= `DPC_OUT_RST;
			nco_inc         <= `DPC_NCO_INC_RST;
			nco_phase       <= '0;
			sample_tick_o   <= 1'b0;
			in_sample       <= '0;
			clr_pulse       <= '0;
			line_out_o      <= `DPC_OUT_RST;
			line_oe_o       <= '0;
			for (int n = 0; n < NUM_CNT; n++) cnt_cfg[n] <= `DPC_CFG_RST;
		end else begin
			aw_held         <= next_aw_held;
			aw_addr         <= next_aw_addr;
			w_held          <= next_w_held;
			w_data          <= next_w_data;
			w_strb          <= next_w_strb;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o  <= next_wready;
			s_axi_bvalid_o  <= next_bvalid;
			s_axi_bresp_o   <= next_bresp;
			s_axi_arready_o <= next_arready;
			s_axi_rvalid_o  <= next_rvalid;
			s_axi_rdata_o   <= next_rdata;
			s_axi_rresp_o   <= next_rresp;
			dir             <= next_dir;
			out_data        <= next_out_data;
			nco_inc         <= next_nco_inc;
			nco_phase       <= next_nco_phase;
			sample_tick_o   <= next_tick;
			in_sample       <= next_in_sample;
			clr_pulse       <= next_clr_pulse;
			line_out_o      <= next_out_data;
			line_oe_o       <= next_line_oe;
			for (int n = 0; n < NUM_CNT; n++) cnt_cfg[n] <= next_cnt_cfg[n];
		end
	end

	// Counters take their inputs only after synchronisation
	for (genvar n = 0; n < NUM_CNT; n++) begin : g_cnt
		count_channel #(
			.PTIME_MAX(PTIME_MAX_CYCLES)
		) u_cnt (
			.clk_sys_i(clk_sys_i),
			.rst_b_i  (rst_b_i),
			.mode_i   (count_mode_t'(cnt_cfg[n][`DPC_CFG_MODE_LSB +: 2])),
			.a_en_i   (cnt_cfg[n][`DPC_CFG_AEN_BIT]),
			.b_en_i   (cnt_cfg[n][`DPC_CFG_BEN_BIT]),
			.r_en_i   (cnt_cfg[n][`DPC_CFG_REN_BIT]),
			.a_i      (line_sync_q[cnt_cfg[n][`DPC_CFG_SELA_LSB +: 5]]),
			.b_i      (line_sync_q[cnt_cfg[n][`DPC_CFG_SELB_LSB +: 5]]),
			.r_i      (line_sync_q[cnt_cfg[n][`DPC_CFG_SELR_LSB +: 5]]),
			.clear_i  (clr_pulse[n]),
			.count_o  (cnt_count[n]),
			.period_o (cnt_period[n])
		);
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	a_group_dir: assert property ($past(dir) == dir |=> line_oe_o == {{8{$past(dir[3])}},
		{8{$past(dir[2])}}, {8{$past(dir[1])}}, {8{$past(dir[0])}}})
		else $error("line enables disagree with group direction");
	a_sample_align: assert property (sample_tick_o |=> in_sample == $past(line_sync_q))
		else $error("digital sample not taken on sample tick");
	a_sample_hold: assert property (!sample_tick_o |=> in_sample == $past(in_sample))
		else $error("digital sample changed between ticks");
	a_trim_tick: assert property (nco_inc == 32'h80000000 && $stable(nco_inc) [*3]
		|-> sample_tick_o != $past(sample_tick_o)) else $error("sample tick ignores trim");
	a_write_resp: assert property (aw_held && w_held && !s_axi_bvalid_o |=> s_axi_bvalid_o)
		else $error("write response missing");

	// Read answer comes one cycle after the address is taken
	a_read_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read response missing");
	a_read_decerr: assert property (s_axi_arvalid_i && s_axi_arready_o && !addr_known({s_axi_araddr_i[7:2], 2'b00})
		|=> s_axi_rresp_o == `DPC_RESP_DECERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	// Unmapped writes answer with an error and touch nothing
	a_write_decerr: assert property (do_write && !wr_hit |=> s_axi_bresp_o == `DPC_RESP_DECERR
		&& $stable(dir) && $stable(out_data) && $stable(nco_inc))
		else $error("unmapped write not refused");
	a_dir_write: assert property (do_write && wr_hit && aw_addr == `DPC_OFS_DIR && w_strb[0]
		|=> dir == $past(w_data[3:0])) else $error("direction write not applied");
	a_out_write: assert property (do_write && wr_hit && aw_addr == `DPC_OFS_OUT && w_strb == 4'hf
		|=> line_out_o == $past(w_data)) else $error("output lines do not follow write");
endmodule

/* File: dpc_cfg.svh */
// Register offsets, field positions, reset values and timing figures of the port/counter unit
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

`define DPC_CLK_PERIOD_PS    64'd40000
`define DPC_PTIME_RES_PS     64'd16670
`define DPC_PTIME_MAX_MS     64'd71580
`define DPC_PS_PER_MS        64'd1000000000

`define DPC_OFS_DIR          8'h00
`define DPC_OFS_OUT          8'h04
`define DPC_OFS_IN_SAMPLE    8'h08
`define DPC_OFS_IN_LIVE      8'h0c
`define DPC_OFS_NCO_INC      8'h10
`define DPC_OFS_CNT_BASE     4'h2
`define DPC_SUB_CFG          2'h0
`define DPC_SUB_COUNT        2'h1
`define DPC_SUB_PERIOD       2'h2

`define DPC_DIR_RST          4'hc
`define DPC_OUT_RST          32'h00000000
`define DPC_NCO_INC_RST      32'h0a3d70a4
`define DPC_CFG_RST          32'h00000000

`define DPC_CFG_MODE_LSB     0
`define DPC_CFG_SELA_LSB     4
`define DPC_CFG_AEN_BIT      9
`define DPC_CFG_SELB_LSB     12
`define DPC_CFG_BEN_BIT      17
`define DPC_CFG_SELR_LSB     20
`define DPC_CFG_REN_BIT      25
`define DPC_CFG_CLR_BIT      31

`define DPC_RESP_OKAY        2'h0
`define DPC_RESP_DECERR      2'h3

`endif

/* File: dpc_pkg.sv */
// Types shared by the port/counter unit
package dpc_pkg;
	typedef enum logic [1:0] {MODE_COUNT, MODE_UPDOWN, MODE_QUAD, MODE_PTIME} count_mode_t;
	typedef logic [31:0] word_t;
endpackage

/* File: line_sync.sv */
// Two-stage synchroniser for a bank of port lines
`timescale 1ns/1ns
module line_sync #(
	parameter int W = 32
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync;

	always_comb begin
		next_stage1 = async_i;
		next_sync   = stage1;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= next_stage1;
			sync_o <= next_sync;
		end
	end
endmodule

/* File: count_channel.sv */
// One 32-bit counter: plain, up/down, quadrature and pulse-time modes
`timescale 1ns/1ns
`include "dpc_cfg.svh"
module count_channel import dpc_pkg::*; #(
	parameter logic [31:0] PTIME_MAX = 32'hffffffff
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire count_mode_t mode_i,
	input  wire logic        a_en_i,
	input  wire logic        b_en_i,
	input  wire logic        r_en_i,
	input  wire logic        a_i,
	input  wire logic        b_i,
	input  wire logic        r_i,
	input  wire logic        clear_i,
	output word_t            count_o,
	output word_t            period_o
);
	logic  prev_a, prev_b, armed, next_armed;
	word_t timer, next_timer, next_count, next_period;
	logic  rise_a, step_q, up_q, active, clr;

	always_comb begin
		rise_a = a_i & ~prev_a;
		// Both phases changing at once is an illegal step and is dropped
		step_q = (a_i ^ prev_a) ^ (b_i ^ prev_b);
		up_q   = a_i ^ prev_b;
		active = a_en_i & ((mode_i == MODE_UPDOWN || mode_i == MODE_QUAD) ? b_en_i : 1'b1);
		clr    = clear_i | (r_en_i & r_i);
		next_count  = count_o;
		next_period = period_o;
		next_timer  = (timer >= PTIME_MAX) ? PTIME_MAX : timer + 32'h1;
		next_armed  = armed;
		if (clr) begin
			next_count = '0;
			next_timer = '0;
			next_armed = 1'b0;
		end else if (active) begin
			case (mode_i)
				MODE_COUNT: if (rise_a) next_count = count_o + 32'h1;
				MODE_UPDOWN: if (rise_a) next_count = b_i ? count_o - 32'h1 : count_o + 32'h1;
				MODE_QUAD: if (step_q) next_count = up_q ? count_o + 32'h1 : count_o - 32'h1;
				MODE_PTIME: if (rise_a) begin
					if (armed) next_period = next_timer;
					next_timer = '0;
					next_armed = 1'b1;
				end
				default: next_count = count_o;
			endcase
		end else begin
			next_armed = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_a   <= 1'b0;
			prev_b   <= 1'b0;
			armed    <= 1'b0;
			timer    <= '0;
			count_o  <= '0;
			period_o <= '0;
		end else begin
			prev_a   <= a_i;
			prev_b   <= b_i;
			armed    <= next_armed;
			timer    <= next_timer;
			count_o  <= next_count;
			period_o <= next_period;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_quad_back;
		!a_i && !b_i ##1 !a_i && b_i;
	endsequence

	a_count_step: assert property (mode_i == MODE_COUNT && active && rise_a && !clr |=>
		count_o == $past(count_o) + 32'h1) else $error("plain count missed a rising edge");
	a_count_wrap: assert property (mode_i == MODE_COUNT && active && rise_a && !clr &&
		count_o == 32'hffffffff |=> count_o == 32'h0) else $error("counter did not wrap to zero");
	a_reset_line: assert property (r_en_i && r_i |=> count_o == 32'h0)
		else $error("routed reset did not clear the count");
	a_quad_reverse: assert property (mode_i == MODE_QUAD && active && !clr ##0 s_quad_back
		##0 ($stable(mode_i) && $stable(active) && !clr) |=> count_o == $past(count_o) - 32'h1)
		else $error("quadrature reverse step not counted down");
	a_idle_hold: assert property (!active && !clr |=> count_o == $past(count_o))
		else $error("unassigned counter changed");
	a_signed_wrap: assert property (mode_i == MODE_UPDOWN && active && rise_a && !b_i && !clr &&
		count_o == 32'h7fffffff |=> count_o == 32'h80000000) else $error("up/down wrap wrong");
	a_ptime_latch: assert property (mode_i == MODE_PTIME && active && armed && rise_a && !clr &&
		timer < PTIME_MAX |=> period_o == $past(timer) + 32'h1 && timer == 32'h0)
		else $error("pulse interval not latched");
endmodule

/* File: field_source.sv */
// Field-side model: pulse trains and an incremental encoder on the port lines
`timescale 1ns/1ns
module field_source (
	input  wire logic        clk_sys_i,
	output logic      [31:0] lines_o
);
	initial lines_o = 32'h00000000;

	// Settle time covers the two-flop synchroniser and the count edge
	task automatic idle();
		repeat (6) @(posedge clk_sys_i);
	endtask

	task automatic set_all(input logic [31:0] v);
		@(posedge clk_sys_i);
		lines_o <= v;
		idle();
	endtask

	task automatic set_line(input int idx, input logic v);
		@(posedge clk_sys_i);
		lines_o[idx] <= v;
		idle();
	endtask

	// Levels last one clock at least; narrower ones slip past a single-clock sampler
	task automatic pulses(input int idx, input int n, input int hi, input int lo);
		@(posedge clk_sys_i);
		repeat (n) begin
			lines_o[idx] <= 1'b1;
			repeat (hi) @(posedge clk_sys_i);
			lines_o[idx] <= 1'b0;
			repeat (lo) @(posedge clk_sys_i);
		end
		idle();
	endtask

	// Gray steps on B and A; forward means A leads B
	task automatic quad(input int a, input int b, input int n, input bit fwd);
		logic [1:0] q;
		q = 2'h0;
		repeat (4 * n) begin
			q = fwd ? q + 2'h1 : q - 2'h1;
			@(posedge clk_sys_i);
			lines_o[a] <= q[1] ^ q[0];
			lines_o[b] <= q[1];
			repeat (2) @(posedge clk_sys_i);
		end
		idle();
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the port and counter unit
`timescale 1ns/1ns
`include "dpc_cfg.svh"
module tb import dpc_pkg::*;;
	logic        clk_sys_i;
	logic        rst_b_i;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, tick;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, line_out, line_oe, src, pads;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	logic [33:0] rexp;
	int          n_errors, checks_done;

	assign pads = (line_oe & line_out) | (~line_oe & src);

	field_source src_m (.clk_sys_i(clk_sys_i), .lines_o(src));

	digital_port_counter_unit #(.NUM_CNT(3), .PTIME_MAX_CYCLES(32'd100)) DUT (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready),
		.line_in_i(pads),
		.line_out_o(line_out),
		.line_oe_o(line_oe),
		.sample_tick_o(tick)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic hang();
		n_errors++;
		$display("ERROR wait expected answer seen none");
		wrap_up();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	task automatic done_t(input string s);
		$display("test %s finished", s);
	endtask

	// Address and data offered together, each dropped at its own handshake
	task automatic wr(input logic [7:0] a, input word_t d, input logic [3:0] s = 4'hf,
		input logic [1:0] e = `DPC_RESP_OKAY);
		int k;
		bq.push_back(e);
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
			k++;
		end while (!bvalid && k < 100);
		bready <= 1'b0;
		if (k >= 100)
			hang();
	endtask

	task automatic rd(input logic [7:0] a, input word_t d, input logic [1:0] e = `DPC_RESP_OKAY);
		int k;
		rq.push_back({e, d});
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			arvalid <= arvalid & ~arready;
			k++;
		end while (!rvalid && k < 100);
		rready <= 1'b0;
		if (k >= 100)
			hang();
	endtask

	// Oldest note is matched against each answer as it is taken
	always @(posedge clk_sys_i) begin
		if (bvalid && bready)
			chk("bresp", 32'(bresp), 32'(bq.pop_front()));
		if (rvalid && rready) begin
			rexp = rq.pop_front();
			chk("rdata", rdata, rexp[31:0]);
			chk("rresp", 32'(rresp), 32'(rexp[33:32]));
		end
	end

	function automatic word_t cfgw(input count_mode_t m, input int a, input int b, input int r,
		input bit ae, input bit be, input bit re);
		return 32'(m) | (32'(a) << `DPC_CFG_SELA_LSB) | (32'(b) << `DPC_CFG_SELB_LSB)
			| (32'(r) << `DPC_CFG_SELR_LSB) | (32'(ae) << `DPC_CFG_AEN_BIT)
			| (32'(be) << `DPC_CFG_BEN_BIT) | (32'(re) << `DPC_CFG_REN_BIT) | (32'h1 << `DPC_CFG_CLR_BIT);
	endfunction

	function automatic logic [7:0] ca(input int n, input int s);
		return 8'(32'h20 + 16 * n + 4 * s);
	endfunction

	initial begin
		#4000000;
		hang();
	end

	initial begin
		word_t r;
		int    n;
		rst_b_i = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		void'($urandom(90));
		cyc(12);
		rst_b_i <= 1'b1;
		cyc(2);
		chk("line_oe", line_oe, 32'hffff0000);
		rd(`DPC_OFS_DIR, 32'(`DPC_DIR_RST));
		rd(`DPC_OFS_NCO_INC, `DPC_NCO_INC_RST);
		rd(ca(0, 0), `DPC_CFG_RST);
		rd(8'h1c, 32'h0, `DPC_RESP_DECERR);
		wr(8'h1c, 32'hffffffff, 4'hf, `DPC_RESP_DECERR);
		done_t("reset");
		r = $urandom();
		wr(`DPC_OFS_DIR, 32'h5);
		wr(`DPC_OFS_OUT, r);
		cyc(2);
		chk("line_oe", line_oe, 32'h00ff00ff);
		chk("line_out", line_out, r);
		wr(`DPC_OFS_OUT, ~r, 4'h2);
		cyc(4);
		chk("line_out", line_out, {r[31:16], ~r[15:8], r[7:0]});
		rd(`DPC_OFS_IN_LIVE, {8'h00, r[23:16], 8'h00, r[7:0]});
		wr(`DPC_OFS_DIR, 32'h0);
		cyc(2);
		chk("line_oe", line_oe, 32'h00000000);
		done_t("ports");
		r = $urandom();
		src_m.set_all(r);
		n = 0;
		while (!tick && n < 100) begin
			cyc(1);
			n++;
		end
		if (n >= 100)
			hang();
		src_m.set_all(~r);
		rd(`DPC_OFS_IN_SAMPLE, r);
		rd(`DPC_OFS_IN_LIVE, ~r);
		for (int s = 1; s <= 2; s++) begin
			wr(`DPC_OFS_NCO_INC, 32'h40000000 << (s - 1));
			cyc(3);
			n = 0;
			repeat (40) begin
				cyc(1);
				n += int'(tick);
			end
			chk("ticks", 32'(n), 32'(10 * s));
		end
		done_t("sampling");
		src_m.set_all(32'h0);
		wr(ca(0, 0), cfgw(MODE_COUNT, 3, 0, 12, 0, 0, 1));
		src_m.pulses(3, 4, 2, 2);
		rd(ca(0, 1), 32'h0);
		wr(ca(0, 0), cfgw(MODE_COUNT, 3, 0, 12, 1, 0, 1));
		n = $urandom_range(20, 1);
		src_m.pulses(3, n, 2, 2);
		src_m.pulses(3, 3, 5, 11);
		rd(ca(0, 1), 32'(n + 3));
		src_m.set_line(12, 1'b1);
		src_m.pulses(3, 2, 2, 2);
		rd(ca(0, 1), 32'h0);
		src_m.set_line(12, 1'b0);
		src_m.pulses(3, 3, 2, 2);
		rd(ca(0, 1), 32'h3);
		done_t("count");
		wr(ca(0, 0), cfgw(MODE_UPDOWN, 3, 9, 0, 1, 1, 0));
		src_m.set_line(9, 1'b1);
		src_m.pulses(3, 2, 2, 2);
		rd(ca(0, 1), 32'hfffffffe);
		// Top byte not written, so the mode changes without a clear
		wr(ca(0, 0), cfgw(MODE_COUNT, 3, 9, 0, 1, 1, 0), 4'h7);
		src_m.pulses(3, 3, 2, 2);
		rd(ca(0, 1), 32'h1);
		wr(ca(0, 0), cfgw(MODE_UPDOWN, 3, 9, 0, 1, 1, 0), 4'h7);
		src_m.set_line(9, 1'b0);
		src_m.pulses(3, 5, 3, 2);
		rd(ca(0, 1), 32'h6);
		wr(ca(0, 0), cfgw(MODE_QUAD, 3, 9, 0, 1, 1, 0));
		src_m.quad(3, 9, 3, 1'b1);
		rd(ca(0, 1), 32'd12);
		src_m.quad(3, 9, 5, 1'b0);
		rd(ca(0, 1), 32'hfffffff8);
		done_t("direction");
		wr(ca(2, 0), cfgw(MODE_PTIME, 20, 0, 0, 1, 0, 0));
		src_m.pulses(20, 3, 3, 4);
		rd(ca(2, 2), 32'd7);
		src_m.pulses(20, 2, 10, 20);
		rd(ca(2, 2), 32'd30);
		rd(ca(0, 1), 32'hfffffff8);
		rd(ca(1, 1), 32'h0);
		done_t("pulse_time");
		rst_b_i <= 1'b0;
		cyc(2);
		rst_b_i <= 1'b1;
		cyc(2);
		chk("line_oe", line_oe, 32'hffff0000);
		rd(ca(0, 1), 32'h0);
		done_t("second_reset");
		wrap_up();
	end
endmodule
